// [src/sc_pkg.sv]
// shared constants, types and register layout of the synth control bank
package sc_pkg;
  // register indices, decoded from control word bits 2:0
  localparam logic [2:0] SC_IDX_INTFRAC = 3'h0;
  localparam logic [2:0] SC_IDX_PHMOD = 3'h1;
  localparam logic [2:0] SC_IDX_REFLOOP = 3'h2;
  localparam logic [2:0] SC_IDX_READBACK = 3'h6;
  localparam int SC_NUM_CTL = 6;
  localparam int SC_ADDR_MSB = 2;
  // register 0 fields
  localparam int SC_INT_BIT = 31;
  localparam int SC_N_MSB = 30;
  localparam int SC_N_LSB = 15;
  localparam int SC_FRAC_MSB = 14;
  localparam int SC_FRAC_LSB = 3;
  // register 1 fields
  localparam int SC_LIN_MSB = 30;
  localparam int SC_LIN_LSB = 29;
  localparam int SC_TEST_MSB = 28;
  localparam int SC_TEST_LSB = 27;
  localparam int SC_PH_MSB = 26;
  localparam int SC_PH_LSB = 15;
  localparam int SC_MOD_MSB = 14;
  localparam int SC_MOD_LSB = 3;
  // register 2 fields
  localparam int SC_NOISE_MSB = 30;
  localparam int SC_NOISE_LSB = 29;
  localparam int SC_PINFN_MSB = 28;
  localparam int SC_PINFN_LSB = 26;
  localparam int SC_RDIV_MSB = 23;
  localparam int SC_RDIV_LSB = 14;
  localparam int SC_LDTYPE_BIT = 8;
  localparam int SC_SHDN_BIT = 5;
  localparam int SC_CNTRST_BIT = 3;
  // register 3 fields
  localparam int SC_ASOFF_BIT = 25;
  localparam int SC_THERM_BIT = 24;
  localparam int SC_DMODE_MSB = 16;
  localparam int SC_DMODE_LSB = 15;
  // register 5 fields
  localparam int SC_PINFN_TOP_BIT = 18;
  localparam int SC_GO_BIT = 6;
  localparam int SC_SRC_MSB = 5;
  localparam int SC_SRC_LSB = 3;
  // readback word field
  localparam int SC_TEMP_LSB = 16;
  // reset values
  localparam logic [31:0] SC_RST_R0 = 32'h007d0000;
  localparam logic [31:0] SC_RST_R1 = 32'h2000fff9;
  localparam logic [31:0] SC_RST_R2 = 32'h00004042;
  localparam logic [31:0] SC_RST_R3 = 32'h0000000b;
  localparam logic [31:0] SC_RST_R4 = 32'h6180b23c;
  localparam logic [31:0] SC_RST_R5 = 32'h00000005;
  // codes
  localparam logic [1:0] SC_DMODE_PHASE = 2'h2;
  localparam logic [2:0] SC_SRC_TEMP = 3'h1;
  localparam logic [3:0] SC_PIN_HIZ = 4'h0;
  localparam logic [3:0] SC_PIN_HIGH = 4'h1;
  localparam logic [3:0] SC_PIN_LOW = 4'h2;
  localparam logic [3:0] SC_PIN_SYNC = 4'h7;
  localparam logic [1:0] SC_NOISE_SPUR1 = 2'h2;
  localparam logic [1:0] SC_NOISE_SPUR2 = 2'h3;
  localparam logic [3:0] SC_AS_TICKS = 4'ha;
  // timing, in printed units, and cycle counts at the system clock
  localparam int SC_CLK_MHZ = 200;
  localparam int SC_T_ADC_US = 100;
  localparam int SC_T_THERM_MS = 100;
  localparam int SC_T_PASS_MS = 20;
  localparam int SC_ADC_CYC = SC_T_ADC_US * SC_CLK_MHZ;
  localparam int SC_THERM_CYC = SC_T_THERM_MS * 1000 * SC_CLK_MHZ;
  localparam int SC_PASS_CYC = SC_T_PASS_MS * 1000 * SC_CLK_MHZ;
  // decoded synthesizer settings handed to the analog side
  typedef struct packed {
    logic int_mode;
    logic [15:0] n_div;
    logic [11:0] frac;
    logic [11:0] modulus;
    logic [9:0] ref_div;
    logic [1:0] modulator_noise_sel;
    logic dither_on;
    logic [1:0] pump_linearity_sel;
    logic [1:0] pump_test_sel;
    logic lock_detect_type;
    logic [3:0] multi_function_pin_sel;
  } sc_cfg_s;
  // reset value of each writable register
  function automatic logic [31:0] sc_ctl_reset(input int idx);
    case (idx)
      0: sc_ctl_reset = SC_RST_R0;
      1: sc_ctl_reset = SC_RST_R1;
      2: sc_ctl_reset = SC_RST_R2;
      3: sc_ctl_reset = SC_RST_R3;
      4: sc_ctl_reset = SC_RST_R4;
      default: sc_ctl_reset = SC_RST_R5;
    endcase
  endfunction : sc_ctl_reset
endpackage : sc_pkg

// [src/sc_sync_align.sv]
// multi-device alignment: pin rising edge becomes a counter reset
`timescale 1ns/10ps
module sc_sync_align
  import sc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // pin and reference
  input wire logic pin_i,
  input wire logic ref_edge,
  input wire logic sync_en,
  // result
  output logic align_pulse
);
  logic pin_prev_reg; // last pin sample
  logic armed_reg; // edge seen, waiting for reference

  // edge detect; pin is synchronous so no extra stages
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      pin_prev_reg <= 1'b0;
    else
      pin_prev_reg <= pin_i;
  end

  // arm on rising edge, fire on next reference edge
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      armed_reg <= 1'b0;
      align_pulse <= 1'b0;
    end
    else
    begin
      align_pulse <= 1'b0;
      if (!sync_en)
        armed_reg <= 1'b0;
      else if (armed_reg && ref_edge)
      begin
        // counters restart aligned to the shared reference
        armed_reg <= 1'b0;
        align_pulse <= 1'b1;
      end
      else if (pin_i && !pin_prev_reg)
        armed_reg <= 1'b1;
    end
  end
endmodule : sc_sync_align

// [src/sc_temp_adc.sv]
// temperature conversion sequencer with a fixed conversion time
`timescale 1ns/10ps
module sc_temp_adc
  import sc_pkg::*;
#(
  parameter int unsigned CONV_CYC = SC_ADC_CYC
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // control from the register bank
  input wire logic go,
  input wire logic [2:0] source_sel,
  input wire logic [6:0] temp_code,
  // result
  output logic [6:0] result,
  output logic busy
);
  logic go_prev_reg; // start edge detect
  logic [31:0] cnt_reg; // conversion time

  // start on rising go with temperature source selected
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      go_prev_reg <= 1'b0;
      busy <= 1'b0;
      cnt_reg <= '0;
      result <= '0;
    end
    else
    begin
      go_prev_reg <= go;
      if (!busy)
      begin
        if (go && !go_prev_reg && source_sel == SC_SRC_TEMP)
        begin
          busy <= 1'b1;
          cnt_reg <= '0;
        end
      end
      else if (cnt_reg == CONV_CYC - 1)
      begin
        // result is the raw 7-bit code; no conversion to degrees
        busy <= 1'b0;
        result <= temp_code;
      end
      else
        cnt_reg <= cnt_reg + 32'h1;
    end
  end
endmodule : sc_temp_adc

// [src/sc_regs.sv]
// synthesizer control register bank with sequencing
//
// What this block does
// - thermal compensation stretches autoselect to 100ms
// - phase step equals phase value over modulus
// - pin rising edge at reference resets counters
// - divider mode 10 applies the phase shift
// - three modulator noise modes, two dithered
// - temperature result is 7-bit code
// - registers kept in low-power mode
// - two passes 20ms apart; second starts autoselect
// - word bits 2:0 select target register
// - bit 31 selects integer or fractional mode
// - fraction is 12-bit field bits 14:3
// - pump linearity field decoded from bits 30:29
// - pump test field decoded from bits 28:27
// - modulus double-buffered, taken on register 0 write
// - pin function is 4 bits split across registers
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
module sc_regs
  import sc_pkg::*;
#(
  parameter int unsigned THERM_CYC = SC_THERM_CYC,
  parameter int unsigned PASS_CYC = SC_PASS_CYC,
  parameter int unsigned ADC_CYC = SC_ADC_CYC
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // register port
  input wire logic [2:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  // timing inputs from the analog side
  input wire logic ref_edge,
  input wire logic autoselect_tick,
  input wire logic [6:0] temp_code,
  // multi-function pin
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  // decoded settings and events
  output sc_cfg_s synth_cfg,
  output logic phase_step,
  output logic [11:0] phase_amount,
  output logic counter_reset,
  output logic autoselect_busy,
  output logic device_enabled
);
  // power-up pass tracking
  typedef enum logic [1:0] {PWR_OFF, PWR_GAP, PWR_READY} sc_pwr_e;
  // autoselect sequencing
  typedef enum logic [1:0] {AS_IDLE, AS_TICKS, AS_THERM} sc_as_e;

  logic [SC_NUM_CTL-1:0][31:0] ctl_reg; // writable registers
  logic [11:0] mod_active_reg; // modulus in use
  logic [9:0] rdiv_active_reg; // reference divider in use
  logic [1:0] dmode_prev_reg; // divider mode last cycle
  logic [31:0] gap_cnt_reg; // pass spacing timer
  logic [31:0] as_cnt_reg; // autoselect timer
  logic [3:0] as_tick_reg; // autoselect tick count
  sc_pwr_e pwr_reg;
  sc_as_e as_reg;
  sc_cfg_s cfg_reg;
  logic [2:0] wr_idx; // target of the incoming word
  logic wr_r0; // register 0 written this cycle
  logic [3:0] pin_fn; // joined pin function code
  logic [6:0] adc_result;
  logic adc_busy;
  logic align_pulse;
  logic [31:0] readback_word;

  // destination comes from the word itself, not from the address port
  assign wr_idx = bus_wdata[SC_ADDR_MSB:0];
  assign wr_r0 = bus_wr && wr_idx == SC_IDX_INTFRAC;
  // top bit lives in register 5, low three in register 2
  assign pin_fn = {ctl_reg[5][SC_PINFN_TOP_BIT],
                   ctl_reg[SC_IDX_REFLOOP][SC_PINFN_MSB:SC_PINFN_LSB]};
  assign readback_word = {9'h0, adc_result, 13'h0, SC_IDX_READBACK};

  // one always_ff per register; whole word lands in one cycle
  generate
    for (genvar i = 0; i < SC_NUM_CTL; i++)
    begin : g_ctl
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
          ctl_reg[i] <= sc_ctl_reset(i);
        // shutdown bit does not touch contents
        else if (bus_wr && wr_idx == 3'(i))
          ctl_reg[i] <= bus_wdata;
      end
    end
  endgenerate

  // double buffers load when register 0 is written
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mod_active_reg <= SC_RST_R1[SC_MOD_MSB:SC_MOD_LSB];
      rdiv_active_reg <= SC_RST_R2[SC_RDIV_MSB:SC_RDIV_LSB];
    end
    else if (wr_r0)
    begin
      // shadow values written earlier, not this cycle's word
      mod_active_reg <= ctl_reg[SC_IDX_PHMOD][SC_MOD_MSB:SC_MOD_LSB];
      rdiv_active_reg <= ctl_reg[SC_IDX_REFLOOP][SC_RDIV_MSB:SC_RDIV_LSB];
    end
  end

  // decoded settings, one cycle behind the registers
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      cfg_reg <= '0;
    else
    begin
      cfg_reg.int_mode <= ctl_reg[0][SC_INT_BIT];
      cfg_reg.n_div <= ctl_reg[0][SC_N_MSB:SC_N_LSB];
      cfg_reg.frac <= ctl_reg[0][SC_FRAC_MSB:SC_FRAC_LSB];
      cfg_reg.modulus <= mod_active_reg;
      cfg_reg.ref_div <= rdiv_active_reg;
      cfg_reg.modulator_noise_sel <=
        ctl_reg[SC_IDX_REFLOOP][SC_NOISE_MSB:SC_NOISE_LSB];
      // reserved code 01 is passed on but never dithers
      cfg_reg.dither_on <=
        ctl_reg[SC_IDX_REFLOOP][SC_NOISE_MSB:SC_NOISE_LSB] == SC_NOISE_SPUR1
        || ctl_reg[SC_IDX_REFLOOP][SC_NOISE_MSB:SC_NOISE_LSB]
        == SC_NOISE_SPUR2;
      cfg_reg.pump_linearity_sel <=
        ctl_reg[SC_IDX_PHMOD][SC_LIN_MSB:SC_LIN_LSB];
      cfg_reg.pump_test_sel <=
        ctl_reg[SC_IDX_PHMOD][SC_TEST_MSB:SC_TEST_LSB];
      cfg_reg.lock_detect_type <= ctl_reg[SC_IDX_REFLOOP][SC_LDTYPE_BIT];
      cfg_reg.multi_function_pin_sel <= pin_fn;
    end
  end
  assign synth_cfg = cfg_reg;

  // power-up passes: first enables, second after the gap starts selection
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pwr_reg <= PWR_OFF;
      gap_cnt_reg <= '0;
      device_enabled <= 1'b0;
    end
    else
    begin
      unique case (pwr_reg)
        PWR_OFF:
          if (wr_r0)
          begin
            pwr_reg <= PWR_GAP;
            device_enabled <= 1'b1;
            gap_cnt_reg <= '0;
          end
        PWR_GAP:
          if (gap_cnt_reg == PASS_CYC - 1)
            pwr_reg <= PWR_READY;
          else
            gap_cnt_reg <= gap_cnt_reg + 32'h1;
        PWR_READY:
          pwr_reg <= PWR_READY;
      endcase
    end
  end

  // autoselect timer: ten ticks, or the long thermal time
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      as_reg <= AS_IDLE;
      as_cnt_reg <= '0;
      as_tick_reg <= '0;
      autoselect_busy <= 1'b0;
    end
    else
    begin
      unique case (as_reg)
        AS_IDLE:
          // a register 0 write during the gap is too early to select
          if (wr_r0 && pwr_reg == PWR_READY
              && !ctl_reg[3][SC_ASOFF_BIT])
          begin
            as_reg <= ctl_reg[3][SC_THERM_BIT] ? AS_THERM : AS_TICKS;
            as_cnt_reg <= '0;
            as_tick_reg <= '0;
            autoselect_busy <= 1'b1;
          end
        AS_TICKS:
          if (autoselect_tick)
          begin
            if (as_tick_reg == SC_AS_TICKS - 4'h1)
            begin
              as_reg <= AS_IDLE;
              autoselect_busy <= 1'b0;
            end
            else
              as_tick_reg <= as_tick_reg + 4'h1;
          end
        AS_THERM:
          if (as_cnt_reg == THERM_CYC - 1)
          begin
            as_reg <= AS_IDLE;
            autoselect_busy <= 1'b0;
          end
          else
            as_cnt_reg <= as_cnt_reg + 32'h1;
        default:
          as_reg <= AS_IDLE;
      endcase
    end
  end

  // phase shift fires on entering divider mode 10 once locked
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dmode_prev_reg <= SC_RST_R3[SC_DMODE_MSB:SC_DMODE_LSB];
      phase_step <= 1'b0;
      phase_amount <= '0;
    end
    else
    begin
      dmode_prev_reg <= ctl_reg[3][SC_DMODE_MSB:SC_DMODE_LSB];
      phase_step <= 1'b0;
      // host must leave mode 10 (any other mode) before another shift is applied
      if (ctl_reg[3][SC_DMODE_MSB:SC_DMODE_LSB] == SC_DMODE_PHASE
          && dmode_prev_reg != SC_DMODE_PHASE && !autoselect_busy)
      begin
        phase_step <= 1'b1;
        // analog side scales this by 360 over the modulus
        phase_amount <= ctl_reg[SC_IDX_PHMOD][SC_PH_MSB:SC_PH_LSB];
      end
    end
  end

  // counter reset from the control bit or from pin alignment
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      counter_reset <= 1'b0;
    else
      counter_reset <= align_pulse
        || ctl_reg[SC_IDX_REFLOOP][SC_CNTRST_BIT];
  end

  // pin driver; sync and high-z both leave the pin undriven
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
    end
    else
    begin
      pin_o <= pin_fn == SC_PIN_HIGH;
      pin_oe <= pin_fn == SC_PIN_HIGH || pin_fn == SC_PIN_LOW;
    end
  end

  // read data stand for one cycle only; index 7 reads zero
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      bus_rdata <= '0;
    else if (!bus_rd)
      bus_rdata <= '0;
    else if (bus_addr == SC_IDX_READBACK)
      bus_rdata <= readback_word;
    else if (bus_addr < 3'(SC_NUM_CTL))
      bus_rdata <= ctl_reg[bus_addr];
    else
      bus_rdata <= '0;
  end

  sc_sync_align u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_i(pin_i),
    .ref_edge(ref_edge),
    .sync_en(pin_fn == SC_PIN_SYNC),
    .align_pulse(align_pulse)
  );

  sc_temp_adc #(.CONV_CYC(ADC_CYC)) u_adc (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .go(ctl_reg[5][SC_GO_BIT]),
    .source_sel(ctl_reg[5][SC_SRC_MSB:SC_SRC_LSB]),
    .temp_code(temp_code),
    .result(adc_result),
    .busy(adc_busy)
  );

  // checks
  property p_word_decode;
    @(posedge sys_clk) disable iff (!rstn)
    wr_r0 |=> ctl_reg[0] == $past(bus_wdata);
  endproperty
  a_word_decode: assert property (p_word_decode)
    else $error("register 0 not loaded from word");

  property p_mod_hold;
    @(posedge sys_clk) disable iff (!rstn)
    !wr_r0 |=> $stable(mod_active_reg);
  endproperty
  a_mod_hold: assert property (p_mod_hold)
    else $error("modulus changed without register 0 write");

  property p_mod_take;
    @(posedge sys_clk) disable iff (!rstn)
    wr_r0 |=> mod_active_reg == $past(ctl_reg[1][SC_MOD_MSB:SC_MOD_LSB]);
  endproperty
  a_mod_take: assert property (p_mod_take)
    else $error("modulus not taken on register 0 write");

  property p_phase;
    @(posedge sys_clk) disable iff (!rstn)
    phase_step |-> phase_amount == $past(ctl_reg[1][SC_PH_MSB:SC_PH_LSB])
      && $past(ctl_reg[3][SC_DMODE_MSB:SC_DMODE_LSB]) == SC_DMODE_PHASE;
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase step without mode 10 or wrong amount");

  property p_phase_once;
    @(posedge sys_clk) disable iff (!rstn)
    phase_step |=> !phase_step;
  endproperty
  a_phase_once: assert property (p_phase_once)
    else $error("phase step longer than one cycle");

  property p_dither;
    @(posedge sys_clk) disable iff (!rstn)
    ##1 synth_cfg.dither_on == $past(ctl_reg[2][SC_NOISE_MSB]);
  endproperty
  a_dither: assert property (p_dither)
    else $error("dither not matching noise code");

  property p_int_mode;
    @(posedge sys_clk) disable iff (!rstn)
    wr_r0 |=> ##1 synth_cfg.int_mode == $past(bus_wdata[SC_INT_BIT], 2);
  endproperty
  a_int_mode: assert property (p_int_mode)
    else $error("mode bit not decoded");

  property p_early_pass;
    @(posedge sys_clk) disable iff (!rstn)
    (pwr_reg != PWR_READY && !autoselect_busy) |=> !autoselect_busy;
  endproperty
  a_early_pass: assert property (p_early_pass)
    else $error("autoselect started before second pass");

  property p_ticks;
    @(posedge sys_clk) disable iff (!rstn)
    // state has already left the tick count when busy drops
    ($fell(autoselect_busy) && $past(as_reg) == AS_TICKS) |->
      $past(as_tick_reg) == SC_AS_TICKS - 4'h1;
  endproperty
  a_ticks: assert property (p_ticks)
    else $error("autoselect ended at wrong tick");

  property p_retain;
    @(posedge sys_clk) disable iff (!rstn)
    (ctl_reg[2][SC_SHDN_BIT] && !bus_wr) |=> $stable(ctl_reg);
  endproperty
  a_retain: assert property (p_retain)
    else $error("registers changed in low-power mode");

  property p_readback;
    @(posedge sys_clk) disable iff (!rstn)
    (bus_rd && bus_addr == SC_IDX_READBACK) |=>
      bus_rdata[SC_TEMP_LSB +: 7] == $past(adc_result);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback does not show result");

  c_phase: cover property (@(posedge sys_clk) disable iff (!rstn)
    phase_step);
  c_align: cover property (@(posedge sys_clk) disable iff (!rstn)
    align_pulse);
  c_conv: cover property (@(posedge sys_clk) disable iff (!rstn)
    $fell(adc_busy));
  c_select: cover property (@(posedge sys_clk) disable iff (!rstn)
    $fell(autoselect_busy));
endmodule : sc_regs

// [test/sc_far_end.sv]
// far-side model: reference timing, autoselect clock, sensor, pin wire
`timescale 1ns/10ps
module sc_far_end
#(
  parameter logic [6:0] TEMP = 7'h2a
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // pin drivers of both parties
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic host_en,
  input wire logic host_val,
  // timing and sensor outputs
  output logic ref_edge,
  output logic autoselect_tick,
  output logic [6:0] temp_code,
  output logic pin_i
);
  logic [2:0] div_cnt; // free-running reference divider
  logic float_val; // no pull on the pin, so undriven it wanders
  assign temp_code = TEMP; // fixed sensor code, checked on readback
  // free counters; a slow reference keeps edges well apart
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      div_cnt <= 3'h0;
      float_val <= 1'b0;
    end
    else
    begin
      div_cnt <= div_cnt + 3'h1;
      float_val <= ~float_val;
    end
  assign ref_edge = (div_cnt == 3'h7);
  assign autoselect_tick = (div_cnt[1:0] == 2'h3);
  // host forcing wins, else the bank, else a changing level
  assign pin_i = host_en ? host_val : (pin_oe ? pin_o : float_val);
endmodule : sc_far_end

// [test/sc_regs_test.sv]
// self-checking bench for the synth control register bank
`timescale 1ns/10ps
module sc_regs_test
  import sc_pkg::*;
;
  logic sys_clk = 1'b0; // 200 MHz clock
  logic rstn = 1'b0; // active-low reset
  logic [2:0] bus_addr = 3'h0; // read index
  logic [31:0] bus_wdata = 32'h0; // write word
  logic bus_wr = 1'b0; // write strobe
  logic bus_rd = 1'b0; // read strobe
  logic host_en = 1'b0; // bench forces the pin
  logic host_val = 1'b0; // forced pin level
  logic [31:0] bus_rdata; // read port
  logic [31:0] rd; // last read value
  logic ref_edge;
  logic autoselect_tick;
  logic pin_i;
  logic pin_o;
  logic pin_oe;
  logic phase_step;
  logic counter_reset;
  logic autoselect_busy;
  logic device_enabled;
  logic [6:0] temp_code;
  logic [11:0] phase_amount;
  sc_cfg_s synth_cfg; // decoded settings
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  // short counts keep the run brief
  sc_regs #(.THERM_CYC(50), .PASS_CYC(20), .ADC_CYC(10)) sc_regs_inst (
    .sys_clk(sys_clk), .rstn(rstn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .ref_edge(ref_edge),
    .autoselect_tick(autoselect_tick), .temp_code(temp_code),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .synth_cfg(synth_cfg), .phase_step(phase_step),
    .phase_amount(phase_amount), .counter_reset(counter_reset),
    .autoselect_busy(autoselect_busy), .device_enabled(device_enabled));
  sc_far_end #(.TEMP(7'h2a)) sc_far_end_inst (
    .sys_clk(sys_clk), .rstn(rstn), .pin_o(pin_o), .pin_oe(pin_oe),
    .host_en(host_en), .host_val(host_val), .ref_edge(ref_edge),
    .autoselect_tick(autoselect_tick), .temp_code(temp_code),
    .pin_i(pin_i));
  always #2.5 sys_clk = ~sys_clk;
  // verdict and end of run
  task automatic close_out;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  // hang guard, far above the expected run length
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      close_out();
    end
  end
  // one comparison; a mismatch is printed and counted
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr(input logic [31:0] w);
    @(posedge sys_clk);
    bus_wr <= 1'b1;
    bus_wdata <= w;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask : wr
  // read strobe; data stands only in the next cycle
  task automatic rdr(input logic [2:0] a);
    @(posedge sys_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 rd = bus_rdata;
  endtask : rdr
  // wait whole cycles, then sample settled outputs
  task automatic cyc_wait(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc_wait
  // register 2 word: reference divider one, doubler and halving off
  function automatic logic [31:0] r2w(input logic [1:0] nz,
                                      input logic [2:0] pf);
    return {1'b0, nz, pf, 2'h0, 10'h001, 11'h008, 3'h2};
  endfunction : r2w
  // register 5 word: pin code top bit, converter start and source
  function automatic logic [31:0] r5w(input logic top, input logic go,
                                      input logic [2:0] src);
    return {13'h0, top, 11'h0, go, src, 3'h5};
  endfunction : r5w
  // main sequence
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    rdr(3'h0);
    chk(rd, SC_RST_R0);
    rdr(3'h2);
    chk(rd, SC_RST_R2);
    chk(device_enabled, 1'b0);
    // modulus waits for a register 0 write
    wr(32'h2000_8919);
    cyc_wait(2);
    chk(synth_cfg.modulus, 12'hfff);
    wr(32'h0032_0028);
    cyc_wait(2);
    chk(synth_cfg.modulus, 12'h123);
    chk(synth_cfg.ref_div, 10'h001);
    chk(synth_cfg.n_div, 16'h0064);
    chk(synth_cfg.frac, 12'h005);
    chk(synth_cfg.int_mode, 1'b0);
    chk(device_enabled, 1'b1);
    // second pass too early must not start autoselect
    wr(32'h0032_0028);
    cyc_wait(2);
    chk(autoselect_busy, 1'b0);
    // outputs muted and register 5 bits 30:29 set before acquisition
    wr(32'h6180_b21c);
    wr(32'h6000_0005);
    cyc_wait(30);
    wr(32'h0032_0028);
    cyc_wait(2);
    chk(autoselect_busy, 1'b1);
    cyc_wait(20);
    chk(autoselect_busy, 1'b1);
    cyc_wait(30);
    chk(autoselect_busy, 1'b0);
    // thermal compensation outlasts ten ticks
    wr(32'h0100_0003);
    wr(32'h0032_0028);
    cyc_wait(45);
    chk(autoselect_busy, 1'b1);
    cyc_wait(15);
    chk(autoselect_busy, 1'b0);
    wr(32'h0000_000b);
    // every pump and noise code
    for (int c = 0; c < 4; c++)
    begin
      wr({1'b0, c[1:0], c[1:0], 12'h2b5, 12'h123, 3'h1});
      wr(r2w(c[1:0], 3'h0));
      cyc_wait(2);
      chk(synth_cfg.pump_linearity_sel, c[1:0]);
      chk(synth_cfg.pump_test_sel, c[1:0]);
      chk(synth_cfg.modulator_noise_sel, c[1:0]);
      chk(synth_cfg.dither_on, c[1]);
    end
    // low-power mode set; address 6 in the word is ignored
    wr(r2w(2'h0, 3'h0) | 32'h0000_0020);
    wr(32'hffff_fffe);
    rdr(3'h1);
    chk(rd, 32'h795a_8919);
    rdr(3'h7);
    chk(rd, 32'h0);
    // phase shift on divider mode 10
    wr(32'h0001_0003);
    n = 0;
    while (phase_step !== 1'b1 && n < 10)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(n < 10, 1'b1);
    chk(phase_amount, 12'h2b5);
    wr(32'h0000_000b);
    // pin drive codes, and the top bit in register 5
    wr(r2w(2'h0, 3'h1));
    cyc_wait(2);
    chk({pin_oe, pin_o}, 2'h3);
    wr(r5w(1'b1, 1'b0, 3'h0));
    cyc_wait(2);
    chk(pin_oe, 1'b0);
    chk(synth_cfg.multi_function_pin_sel, 4'h9);
    wr(r5w(1'b0, 1'b0, 3'h0));
    wr(r2w(2'h0, 3'h2));
    cyc_wait(2);
    chk({pin_oe, pin_o}, 2'h2);
    // alignment: pin held low, sync code, then rising edge
    host_en <= 1'b1;
    host_val <= 1'b0;
    wr(r2w(2'h0, 3'h7));
    cyc_wait(4);
    chk(counter_reset, 1'b0);
    host_val <= 1'b1;
    n = 0;
    while (counter_reset !== 1'b1 && n < 30)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(n < 30, 1'b1);
    host_val <= 1'b0;
    wr(r2w(2'h0, 3'h0));
    host_en <= 1'b0;
    // temperature conversion and readback
    wr(r5w(1'b0, 1'b1, 3'h1));
    cyc_wait(15);
    rdr(3'h6);
    chk(rd[22:16], 7'h2a);
    chk(rd[2:0], 3'h6);
    wr(r5w(1'b0, 1'b0, 3'h0));
    close_out();
  end
endmodule : sc_regs_test
